// File: design/dsrc_ctrl.sv
// Standby, soft reset, zero flag and counter resynchronisation control
`default_nettype none
`include "dsrc_map.svh"

// Contract
// - Standby after over 1 us without clock
// - Clock-stop standby halts logic, floats outputs
// - Clock return resumes when both bits set
// - Zero detection off while clock stopped
// - Standby bit zero halts logic, floats outputs
// - Zero detection keeps running in bit standby
// - Standby state follows within 2-3 periods
// - Soft reset clears logic, outputs at common
// - Zero flags rise on reset write, fall later
// - Internal reset follows bit in 3-4 periods
// - Resync resets internal oversampling counter
// - Resync valid: zeros, attenuation, or reset
// - Align to edge chosen by format
// - Resync enable bit zero disables resync in register control mode
// - Long zero run on a channel raises that channel's flag
// - Aligned counter is never reset
// - Resync valid right at reset write
// - Select pin picks serial or I2C port
// - Power-down pin restores register defaults
// - Clock-stop standby only when control bit zero
// - Zero flags low while powered down
module dsrc_ctrl #(
  parameter logic [`DSRC_ZCNT_W-1:0] ZERO_RUN = `DSRC_ZCNT_W'(`DSRC_ZERO_RUN)
) (
  // Clock, reset, enable
  input  wire logic                  clock_i,
  input  wire logic                  reset_i,
  input  wire logic                  ce_i,
  // Pins from outside
  input  wire logic                  power_down_pin_n_i,
  input  wire logic                  regulator_enable_pin_i,
  input  wire logic                  master_clock_i,
  input  wire logic                  frame_clock_i,
  input  wire logic                  ext_filter_word_clock_i,
  input  wire logic                  interface_select_pin_i,
  // Control bits and sample stream
  input  wire dsrc_pkg::dsrc_ctrl_s   ctrl_i,
  input  wire dsrc_pkg::dsrc_sample_s sample_i,
  input  wire logic                  os_tick_i,
  // Status and power controls
  output dsrc_pkg::dsrc_mode_e       mode_o,
  output logic                       digital_run_o,
  output logic                       analog_on_o,
  output logic                       analog_float_o,
  output logic                       common_voltage_level_o,
  output logic                       bias_on_o,
  output logic                       regulator_on_o,
  output logic                       regs_default_o,
  output logic                       internal_reset_n_o,
  // Zero flags
  output logic                       zero_flag_left_o,
  output logic                       zero_flag_right_o,
  // Resynchronisation
  output logic                       resync_valid_o,
  output logic                       counter_reset_o,
  output dsrc_pkg::dsrc_os_count_t   os_count_o,
  // Control port select
  output logic                       use_i2c_o,
  output logic                       use_three_wire_o
);
  import dsrc_pkg::*;

  function automatic logic rise(input logic now, input logic prev);
    return now & ~prev;
  endfunction : rise

  logic [`DSRC_PIN_W-1:0]  pin_raw;
  logic [`DSRC_PIN_W-1:0]  pin_meta;
  logic [`DSRC_PIN_W-1:0]  pin_sync;
  logic [`DSRC_PIN_W-1:0]  pin_last;
  logic                    pd_n;
  logic                    mclk_edge;
  logic                    frame_rise;
  logic                    frame_fall;
  logic                    wck_rise;
  logic                    fs_tick;
  logic [`DSRC_GAP_W-1:0]  gap_cnt;
  logic                    clk_stopped;
  logic                    mclk_stopped;
  logic [1:0]              req;
  logic [1:0]              int_state;
  logic [`DSRC_TCNT_W-1:0] tcnt [2];
  logic                    stby_int;
  logic                    rst_int;
  logic                    rst_bit_last;
  logic                    rst_int_last;
  logic                    rflag;
  logic                    rflag_armed;
  logic [`DSRC_TCNT_W-1:0] rcnt;
  logic [`DSRC_ZCNT_W-1:0] zcnt [2];
  logic [1:0]              zdet;
  logic [1:0]              ch_zero;
  logic                    zero_ok;
  logic                    sync_valid;
  logic                    align_edge;
  dsrc_os_count_t          os_cnt;
  dsrc_mode_e              mode;
  dsrc_mode_e              next_mode;

  // Pin synchronisers
  assign pin_raw = {regulator_enable_pin_i, interface_select_pin_i, ext_filter_word_clock_i,
                    frame_clock_i,
                    master_clock_i, power_down_pin_n_i};

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      pin_meta <= `DSRC_PIN_RST;
      pin_sync <= `DSRC_PIN_RST;
      pin_last <= `DSRC_PIN_RST;
    end else if (ce_i) begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  assign pd_n       = pin_sync[`DSRC_PIN_PDN];
  assign mclk_edge  = pin_sync[`DSRC_PIN_MCLK] ^ pin_last[`DSRC_PIN_MCLK];
  assign frame_rise = rise(pin_sync[`DSRC_PIN_FRAME], pin_last[`DSRC_PIN_FRAME]);
  assign frame_fall = rise(pin_last[`DSRC_PIN_FRAME], pin_sync[`DSRC_PIN_FRAME]);
  assign wck_rise   = rise(pin_sync[`DSRC_PIN_WCK], pin_last[`DSRC_PIN_WCK]);
  assign fs_tick    = ctrl_i.external_filter_mode ? wck_rise : frame_rise;

  // Clock gap timer on the system clock
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      gap_cnt     <= `DSRC_GAP_RST;
      clk_stopped <= 1'b0;
    end else if (ce_i) begin
      if (!pd_n || mclk_edge) begin
        gap_cnt     <= `DSRC_GAP_RST;
        clk_stopped <= 1'b0;
      end else if (gap_cnt != `DSRC_GAP_W'(`DSRC_STOP_CYC)) begin
        gap_cnt <= gap_cnt + `DSRC_GAP_W'(1);
      end else begin
        clk_stopped <= 1'b1;
      end
    end
  end

  assign mclk_stopped = clk_stopped & ~ctrl_i.clock_stop_standby_ctrl;

  // Delayed internal standby and reset states
  assign req = {ctrl_i.soft_reset_release_bit, ctrl_i.standby_release_bit};

  for (genvar i = 0; i < 2; i++) begin : g_delay
    localparam logic [`DSRC_TCNT_W-1:0] LIM =
      (i == 0) ? `DSRC_TCNT_W'(`DSRC_STBY_FS - 1) : `DSRC_TCNT_W'(`DSRC_RST_FS - 1);
    always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
        int_state[i] <= 1'(`DSRC_INT_RST >> i);
        tcnt[i]      <= `DSRC_TCNT_RST;
      end else if (ce_i) begin
        if (!pd_n) begin
          int_state[i] <= 1'b0;
          tcnt[i]      <= `DSRC_TCNT_RST;
        end else if (req[i] == int_state[i]) begin
          tcnt[i] <= `DSRC_TCNT_RST;
        end else if (fs_tick) begin
          if (tcnt[i] == LIM) begin
            int_state[i] <= req[i];
            tcnt[i]      <= `DSRC_TCNT_RST;
          end else begin
            tcnt[i] <= tcnt[i] + `DSRC_TCNT_W'(1);
          end
        end
      end
    end
  end

  assign stby_int = int_state[0];
  assign rst_int  = int_state[1];

  // Flag raised by a soft reset write
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      rst_bit_last <= 1'b0;
      rst_int_last <= 1'b0;
      rflag        <= 1'b0;
      rflag_armed  <= 1'b0;
      rcnt         <= `DSRC_TCNT_RST;
    end else if (ce_i) begin
      rst_bit_last <= ctrl_i.soft_reset_release_bit;
      rst_int_last <= rst_int;
      if (!pd_n) begin
        rflag       <= 1'b0;
        rflag_armed <= 1'b0;
      end else if (rst_bit_last && !ctrl_i.soft_reset_release_bit) begin
        rflag       <= 1'b1;
        rflag_armed <= 1'b0;
      end else if (rise(rst_int, rst_int_last)) begin
        rflag_armed <= rflag;
        rcnt        <= `DSRC_TCNT_RST;
      end else if (rflag_armed && fs_tick) begin
        if (rcnt == `DSRC_TCNT_W'(`DSRC_ZF_FS - 1)) begin
          rflag       <= 1'b0;
          rflag_armed <= 1'b0;
        end else begin
          rcnt <= rcnt + `DSRC_TCNT_W'(1);
        end
      end
    end
  end

  // Zero run detectors, one per channel
  assign ch_zero = {sample_i.right_zero, sample_i.left_zero} | {2{sample_i.atten_zero}};

  for (genvar c = 0; c < 2; c++) begin : g_zero
    always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
        zcnt[c] <= `DSRC_ZCNT_RST;
      end else if (ce_i) begin
        if (!pd_n || mclk_stopped || !rst_int) begin
          zcnt[c] <= `DSRC_ZCNT_RST;
        end else if (sample_i.valid) begin
          if (!ch_zero[c]) begin
            zcnt[c] <= `DSRC_ZCNT_RST;
          end else if (zcnt[c] != ZERO_RUN) begin
            zcnt[c] <= zcnt[c] + `DSRC_ZCNT_W'(1);
          end
        end
      end
    end
    assign zdet[c] = (zcnt[c] == ZERO_RUN);
  end

  assign zero_ok = pd_n & ~mclk_stopped & ctrl_i.zero_flag_enable;

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      zero_flag_left_o  <= 1'b0;
      zero_flag_right_o <= 1'b0;
    end else if (ce_i) begin
      zero_flag_left_o  <= zero_ok & (zdet[0] | rflag);
      zero_flag_right_o <= zero_ok & (zdet[1] | rflag);
    end
  end

  // Resynchronisation of the oversampling counter
  assign sync_valid = pd_n
                    & (~ctrl_i.register_control_mode | ctrl_i.resync_enable_bit)
                    & ((zdet[0] & zdet[1]) | ~ctrl_i.soft_reset_release_bit);

  assign align_edge = ctrl_i.external_filter_mode ? wck_rise :
                      (ctrl_i.i2s_format ? frame_fall : frame_rise);

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      os_cnt          <= `DSRC_OS_RST;
      counter_reset_o <= 1'b0;
      resync_valid_o  <= 1'b0;
    end else if (ce_i) begin
      resync_valid_o  <= sync_valid;
      counter_reset_o <= 1'b0;
      if (!pd_n) begin
        os_cnt <= `DSRC_OS_RST;
      end else if (sync_valid && align_edge && os_cnt != `DSRC_OS_RST) begin
        // Restart keeps this tick, so an aligned edge later reads zero
        os_cnt          <= dsrc_os_count_t'(os_tick_i);
        counter_reset_o <= 1'b1;
      end else if (os_tick_i) begin
        os_cnt <= os_cnt + 8'h01;
      end
    end
  end

  assign os_count_o = os_cnt;

  // Power mode
  always_comb begin
    if (!pd_n) begin
      next_mode = DSRC_OFF;
    end else if (mclk_stopped) begin
      next_mode = DSRC_CLKSTOP;
    end else if (!stby_int) begin
      next_mode = DSRC_STANDBY;
    end else if (!rst_int) begin
      next_mode = DSRC_RESET;
    end else begin
      next_mode = DSRC_RUN;
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      mode <= DSRC_OFF;
    end else if (ce_i) begin
      mode <= next_mode;
    end
  end

  assign mode_o = mode;

  // Power controls decoded from the mode
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      digital_run_o          <= 1'b0;
      analog_on_o            <= 1'b0;
      analog_float_o         <= 1'b1;
      common_voltage_level_o <= 1'b0;
    end else if (ce_i) begin
      unique case (mode)
        DSRC_OFF, DSRC_CLKSTOP, DSRC_STANDBY: begin
          digital_run_o          <= 1'b0;
          analog_on_o            <= 1'b0;
          analog_float_o         <= 1'b1;
          common_voltage_level_o <= 1'b0;
        end
        DSRC_RESET: begin
          digital_run_o          <= 1'b0;
          analog_on_o            <= 1'b1;
          analog_float_o         <= 1'b0;
          common_voltage_level_o <= 1'b1;
        end
        DSRC_RUN: begin
          digital_run_o          <= 1'b1;
          analog_on_o            <= 1'b1;
          analog_float_o         <= 1'b0;
          common_voltage_level_o <= 1'b0;
        end
        default: begin
          digital_run_o          <= 1'b0;
          analog_on_o            <= 1'b0;
          analog_float_o         <= 1'b1;
          common_voltage_level_o <= 1'b0;
        end
      endcase
    end
  end

  // Supplies, register defaults and port select
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      bias_on_o          <= 1'b0;
      regulator_on_o     <= 1'b0;
      regs_default_o     <= 1'b1;
      internal_reset_n_o <= 1'b0;
      use_i2c_o          <= 1'b0;
      use_three_wire_o   <= 1'b0;
    end else if (ce_i) begin
      bias_on_o          <= pd_n;
      regulator_on_o     <= pd_n & pin_sync[`DSRC_PIN_LDO];
      regs_default_o     <= ~pd_n;
      internal_reset_n_o <= rst_int;
      use_i2c_o          <= ctrl_i.register_control_mode & pin_sync[`DSRC_PIN_IFSEL];
      use_three_wire_o   <= ctrl_i.register_control_mode & ~pin_sync[`DSRC_PIN_IFSEL];
    end
  end

  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i || !ce_i);

  stop_detect_time_a: assert property ($rose(clk_stopped) |->
    $past(gap_cnt) == `DSRC_GAP_W'(`DSRC_STOP_CYC)) else $error("clock stop timing wrong");
  clkstop_halt_a: assert property (mode == DSRC_CLKSTOP |=>
    analog_float_o && !digital_run_o) else $error("clock stop did not halt");
  clock_resume_a: assert property (mode == DSRC_CLKSTOP && pd_n && !mclk_stopped &&
    stby_int && rst_int |=> mode == DSRC_RUN) else $error("no resume after clock return");
  zero_off_stop_a: assert property (mclk_stopped |=>
    !zero_flag_left_o && !zero_flag_right_o) else $error("zero flag while clock stopped");
  standby_float_a: assert property (mode == DSRC_STANDBY |=>
    analog_float_o && !analog_on_o) else $error("standby outputs not floating");
  standby_delay_a: assert property ($changed(stby_int) && $past(pd_n) |->
    $past(fs_tick) && $past(tcnt[0]) == `DSRC_TCNT_W'(`DSRC_STBY_FS - 1))
    else $error("standby change timing wrong");
  reset_delay_a: assert property ($changed(rst_int) && $past(pd_n) |->
    $past(fs_tick) && $past(tcnt[1]) == `DSRC_TCNT_W'(`DSRC_RST_FS - 1))
    else $error("internal reset timing wrong");
  reset_common_a: assert property (mode == DSRC_RESET |=>
    common_voltage_level_o && !digital_run_o) else $error("reset outputs wrong");
  zflag_set_a: assert property (pd_n && rst_bit_last && !ctrl_i.soft_reset_release_bit |=>
    rflag) else $error("reset flag not raised");
  zflag_pd_a: assert property (!pd_n |=>
    !zero_flag_left_o && !zero_flag_right_o) else $error("zero flag in power down");
  resync_gate_a: assert property (ctrl_i.register_control_mode &&
    !ctrl_i.resync_enable_bit |-> !sync_valid) else $error("resync not disabled");
  aligned_keep_a: assert property (counter_reset_o |->
    $past(sync_valid) && $past(align_edge) && $past(os_cnt) != `DSRC_OS_RST)
    else $error("counter reset without cause");

  clock_resume_c: cover property (mode == DSRC_CLKSTOP ##1 mode == DSRC_RUN);
  standby_enter_c: cover property (mode == DSRC_RUN ##1 mode == DSRC_STANDBY);
  counter_reset_c: cover property (counter_reset_o);
  zflag_release_c: cover property ($fell(rflag) && pd_n);

endmodule : dsrc_ctrl
`default_nettype wire

// File: design/dsrc_map.svh
// Named constants for the standby, reset and resynchronisation controller
`ifndef DSRC_MAP_SVH
`define DSRC_MAP_SVH

`define DSRC_CLK_PERIOD_PS 5000
`define DSRC_STOP_TIME_PS  1000000
`define DSRC_STOP_CYC      ((`DSRC_STOP_TIME_PS + `DSRC_CLK_PERIOD_PS - 1) / `DSRC_CLK_PERIOD_PS)
`define DSRC_GAP_W         8
`define DSRC_GAP_RST       8'h00

`define DSRC_STBY_FS       3
`define DSRC_RST_FS        4
`define DSRC_ZF_FS         2
`define DSRC_TCNT_W        3
`define DSRC_TCNT_RST      3'h0

`define DSRC_ZERO_RUN      8192
`define DSRC_ZCNT_W        14
`define DSRC_ZCNT_RST      14'h0000

`define DSRC_PIN_W         6
`define DSRC_PIN_RST       6'h00
`define DSRC_PIN_PDN       0
`define DSRC_PIN_MCLK      1
`define DSRC_PIN_FRAME     2
`define DSRC_PIN_WCK       3
`define DSRC_PIN_IFSEL     4
`define DSRC_PIN_LDO       5

`define DSRC_OS_RST        8'h00
`define DSRC_INT_RST       2'h0

`endif

// File: design/dsrc_pkg.sv
// Types shared by the standby, reset and resynchronisation controller
`default_nettype none
package dsrc_pkg;

  typedef enum logic [2:0] {
    DSRC_OFF     = 3'b000,
    DSRC_CLKSTOP = 3'b001,
    DSRC_STANDBY = 3'b010,
    DSRC_RESET   = 3'b011,
    DSRC_RUN     = 3'b100
  } dsrc_mode_e;

  typedef struct packed {
    logic standby_release_bit;
    logic soft_reset_release_bit;
    logic resync_enable_bit;
    logic clock_stop_standby_ctrl;
    logic zero_flag_enable;
    logic register_control_mode;
    logic i2s_format;
    logic external_filter_mode;
  } dsrc_ctrl_s;

  typedef struct packed {
    logic valid;
    logic left_zero;
    logic right_zero;
    logic atten_zero;
  } dsrc_sample_s;

  typedef logic [7:0] dsrc_os_count_t;

endpackage : dsrc_pkg
`default_nettype wire

// File: test/dsrc_host_model.sv
// Host side model: master clock, frame clock, oversampling ticks, samples
`default_nettype none
module dsrc_host_model (
  // Clock
  input  wire logic              clock_i,
  // Bench controls
  input  wire logic              mclk_run_i,
  input  wire logic              silence_i,
  input  wire logic [1:0]        noise_i,
  // Toward the block
  output logic                   master_clock_o,
  output logic                   frame_clock_o,
  output logic                   os_tick_o,
  output dsrc_pkg::dsrc_sample_s sample_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import dsrc_pkg::*;
  int unsigned phase = 37;
  initial begin
    master_clock_o = 1'b0;
    frame_clock_o  = 1'b0;
    os_tick_o      = 1'b1;
    sample_o       = '0;
  end
  // Frame of 256 ticks; master clock stands still while stopped
  always @(posedge clock_i) begin
    #1;
    if (mclk_run_i) master_clock_o <= ~master_clock_o;
    phase = (phase + 1) % 256;
    frame_clock_o        <= (phase >= 128);
    sample_o.valid       <= (phase == 0);
    sample_o.left_zero   <= silence_i | noise_i[0];
    sample_o.right_zero  <= silence_i | noise_i[1];
    sample_o.atten_zero  <= 1'b0;
  end
endmodule : dsrc_host_model
`default_nettype wire

// File: test/dsrc_tb.sv
// Self-checking bench for the standby, reset and resynchronisation control
`default_nettype none
module dac_standby_reset_sync_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dsrc_pkg::*;
  localparam int TICK = 256;
  logic           clock_i = 1'b0;
  logic           reset_i = 1'b1;
  logic           pd_n    = 1'b0;
  logic           reg_en  = 1'b1;
  logic           sel     = 1'b1;
  logic           run     = 1'b1;
  logic           sil     = 1'b0;
  logic [1:0]     noise   = 2'h0;
  dsrc_ctrl_s     ctrl    = '0;
  dsrc_sample_s   smp;
  dsrc_mode_e     mode;
  dsrc_os_count_t osc;
  logic           mclk, frame, tick, dig_run, an_on, an_float, vcm, bias, reg_on;
  logic           regs_def, irst_n, zfl, zfr, rv, crst, i2c, w3;
  int             n_mismatch = 0;
  int             num_checks = 0;
  int             cyc        = 0;
  int             npulse     = 0;
  int             n;

  always #2.5 clock_i = ~clock_i;

  dsrc_host_model u_dsrc_host_model (
    .clock_i(clock_i), .mclk_run_i(run), .silence_i(sil), .noise_i(noise),
    .master_clock_o(mclk), .frame_clock_o(frame), .os_tick_o(tick), .sample_o(smp)
  );

  dsrc_ctrl #(.ZERO_RUN(14'h0008)) u_dsrc_ctrl (
    .clock_i(clock_i), .reset_i(reset_i), .ce_i(1'b1), .power_down_pin_n_i(pd_n),
    .regulator_enable_pin_i(reg_en), .master_clock_i(mclk), .frame_clock_i(frame),
    .ext_filter_word_clock_i(frame), .interface_select_pin_i(sel), .ctrl_i(ctrl),
    .sample_i(smp), .os_tick_i(tick), .mode_o(mode), .digital_run_o(dig_run),
    .analog_on_o(an_on), .analog_float_o(an_float), .common_voltage_level_o(vcm),
    .bias_on_o(bias), .regulator_on_o(reg_on), .regs_default_o(regs_def),
    .internal_reset_n_o(irst_n), .zero_flag_left_o(zfl), .zero_flag_right_o(zfr),
    .resync_valid_o(rv), .counter_reset_o(crst), .os_count_o(osc),
    .use_i2c_o(i2c), .use_three_wire_o(w3)
  );

  always @(posedge clock_i) begin
    cyc++;
    if (crst === 1'b1) npulse++;
    if (cyc == 60000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  // Random non-silent data: never both channels zero
  always @(posedge clock_i) begin
    #1;
    noise = ($urandom % 8 == 0) ? 2'(1 + $urandom % 2) : 2'h0;
  end

  // Reference mode from the documented priority
  function automatic dsrc_mode_e exp_mode(int pd, int stop, int stby, int rst);
    if (pd == 0) return DSRC_OFF;
    if (stop != 0) return DSRC_CLKSTOP;
    if (stby == 0) return DSRC_STANDBY;
    if (rst == 0) return DSRC_RESET;
    return DSRC_RUN;
  endfunction : exp_mode

  function automatic logic pick(int w);
    case (w)
      0:       return irst_n;
      1:       return zfl;
      default: return regs_def;
    endcase
  endfunction : pick

  task automatic step(int k);
    repeat (k) @(posedge clock_i);
    #1;
  endtask : step

  task automatic check_val(logic [31:0] got, logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check_val

  task automatic check_mode(dsrc_mode_e got, dsrc_mode_e exp);
    check_val(32'(got), 32'(exp));
  endtask : check_mode

  task automatic check_range(int got, int lo, int hi);
    num_checks++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("Error at %0t: got %0h expected %0h..%0h", $time, got, lo, hi);
    end
  endtask : check_range

  task automatic wait_mode(dsrc_mode_e e, int lim, output int k);
    k = 0;
    while (mode !== e && k < lim) begin
      step(1);
      k++;
    end
    check_mode(mode, e);
  endtask : wait_mode

  task automatic wait_sig(int w, logic e, int lim, output int k);
    k = 0;
    while (pick(w) !== e && k < lim) begin
      step(1);
      k++;
    end
    check_val(32'(pick(w)), 32'(e));
  endtask : wait_sig

  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  initial begin
    void'($urandom(34));
    ctrl.standby_release_bit    = 1'b1;
    ctrl.soft_reset_release_bit = 1'b1;
    ctrl.resync_enable_bit      = 1'b1;
    ctrl.zero_flag_enable       = 1'b1;
    ctrl.register_control_mode  = 1'b1;
    step(5);
    check_mode(mode, DSRC_OFF);
    check_val({an_float, regs_def, zfl}, 3'h6);
    reset_i = 1'b0;
    pd_n    = 1'b1;
    wait_mode(exp_mode(1, 0, 1, 1), 4 * TICK + 40, n);
    step(2);
    check_val({dig_run, an_on, bias, reg_on, regs_def}, 5'h1E);
    check_val({i2c, w3}, 2'h2);
    sel = 1'b0;
    reg_en = 1'b0;
    step(6);
    check_val({i2c, w3, reg_on}, 3'h2);
    reg_en = 1'b1;
    // Clock stop standby and its control bit
    run = 1'b0;
    wait_mode(exp_mode(1, 1, 1, 1), 260, n);
    check_range(n, 195, 212);
    step(2);
    check_val({an_float, dig_run, bias}, 3'h5);
    run = 1'b1;
    wait_mode(DSRC_RUN, 12, n);
    ctrl.clock_stop_standby_ctrl = 1'b1;
    run = 1'b0;
    step(300);
    check_mode(mode, DSRC_RUN);
    run = 1'b1;
    ctrl.clock_stop_standby_ctrl = 1'b0;
    // Zero run, resync enable, detection off while clock stopped
    sil = 1'b1;
    wait_sig(1, 1'b1, 10 * TICK, n);
    check_val({zfr, rv}, 2'h3);
    ctrl.resync_enable_bit = 1'b0;
    step(2);
    check_val(rv, 1'b0);
    ctrl.resync_enable_bit = 1'b1;
    run = 1'b0;
    wait_mode(DSRC_CLKSTOP, 260, n);
    step(2);
    check_val({zfl, zfr}, 2'h0);
    run = 1'b1;
    // Standby bit
    ctrl.standby_release_bit = 1'b0;
    wait_mode(exp_mode(1, 0, 0, 1), 4 * TICK, n);
    check_range(n, 2 * TICK, 3 * TICK + 10);
    step(2);
    check_val({an_float, dig_run, bias, regs_def}, 4'hA);
    wait_sig(1, 1'b1, 10 * TICK, n);
    ctrl.standby_release_bit = 1'b1;
    wait_mode(DSRC_RUN, 4 * TICK, n);
    check_range(n, 2 * TICK, 3 * TICK + 10);
    sil = 1'b0;
    wait_sig(1, 1'b0, 4 * TICK, n);
    // Soft reset and resynchronisation, first on the I2S edge
    ctrl.i2s_format = 1'b1;
    step(2 * TICK);
    sil = 1'b1;
    step(2 * TICK);
    npulse = 0;
    ctrl.soft_reset_release_bit = 1'b0;
    step(1);
    check_val(rv, 1'b1);
    wait_sig(1, 1'b1, 4, n);
    check_val(zfr, 1'b1);
    wait_sig(0, 1'b0, 5 * TICK, n);
    check_range(n, 3 * TICK - 10, 4 * TICK + 10);
    step(2);
    check_mode(mode, exp_mode(1, 0, 1, 0));
    check_val({vcm, an_float, dig_run, regs_def}, 4'h8);
    step(TICK);
    check_val(npulse, 1);
    ctrl.i2s_format = 1'b0;
    step(TICK + 10);
    check_val(npulse, 2);
    step(2 * TICK);
    ctrl.soft_reset_release_bit = 1'b1;
    wait_sig(0, 1'b1, 5 * TICK, n);
    check_range(n, 3 * TICK - 10, 4 * TICK + 10);
    wait_sig(1, 1'b0, 3 * TICK, n);
    check_range(n, TICK - 4, 2 * TICK + 10);
    check_val(zfr, 1'b0);
    wait_mode(DSRC_RUN, 4, n);
    // Power down pin
    sil = 1'b1;
    wait_sig(1, 1'b1, 10 * TICK, n);
    pd_n = 1'b0;
    wait_sig(2, 1'b1, 8, n);
    step(2);
    check_val({zfl, zfr, an_float}, 3'h1);
    check_mode(mode, exp_mode(0, 0, 1, 1));
    give_verdict();
  end
endmodule : dac_standby_reset_sync_control_tb_top
`default_nettype wire
